// [verilog/csfw_pkg.sv]
// package for the program status word block: field positions, reset value, widths
package csfw_pkg;
	// ***********************************************
	// widths
	// ***********************************************
	localparam int WORD_W = 8;       // status word width
	localparam int ADDR_W = 8;       // register port address width
	localparam int DMEM_W = 8;       // internal data memory address width
	localparam int REG_IDX_W = 3;    // working register index width
	localparam int BANK_W = 2;       // bank select width
	// ***********************************************
	// register map
	// ***********************************************
	localparam logic [7:0] STATUS_WORD_OFFSET = 8'hD0;  // status word address
	localparam logic [7:0] STATUS_WORD_RESET = 8'h00;   // value after reset
	// ***********************************************
	// field positions
	// ***********************************************
	localparam int CARRY_BIT = 7;      // carry or borrow
	localparam int HALF_BIT = 6;       // nibble carry or borrow
	localparam int USER0_BIT = 5;      // software flag zero
	localparam int BANK_HI_BIT = 4;    // bank select upper bit
	localparam int BANK_LO_BIT = 3;    // bank select lower bit
	localparam int EXCESS_BIT = 2;     // signed excess flag
	localparam int USER1_BIT = 1;      // software flag one
	localparam int PARITY_BIT = 0;     // accumulator parity
	// ***********************************************
	// bank geometry
	// ***********************************************
	localparam int BANK_SHIFT = 3;     // eight bytes per bank
endpackage : csfw_pkg

// [verilog/csfw_bank_addr.sv]
// working register address former: bank base plus register index
`timescale 1ns/1ps
module csfw_bank_addr (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [csfw_pkg::BANK_W-1:0] i_bank,
	input wire logic [csfw_pkg::REG_IDX_W-1:0] i_reg_idx,
	output logic [csfw_pkg::DMEM_W-1:0] o_dmem_addr
);
	import csfw_pkg::*;

	// ***********************************************
	// address register
	// ***********************************************
	// registered so the top output comes straight from a flip-flop
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dmem_addr <= 8'h00;
		end else begin
			// base is bank times eight, index fills the low bits
			o_dmem_addr <= {3'h0, i_bank, i_reg_idx};
		end
	end

	// assertions
	a_bank_addr_form: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		1'b1 |=> o_dmem_addr == ({6'h00, $past(i_bank)} << BANK_SHIFT)
			+ {5'h00, $past(i_reg_idx)})
		else $error("working register address wrong");
	a_bank_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		$past(i_bank) == 2'h3 |-> o_dmem_addr >= 8'h18 && o_dmem_addr <= 8'h1F)
		else $error("bank three address outside range");
	c_bank_two: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_dmem_addr == 8'h10);
endmodule : csfw_bank_addr

// [verilog/csfw_status_word.sv]
// program status word: arithmetic flags, software flags, bank select, parity
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module csfw_status_word (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [csfw_pkg::ADDR_W-1:0] i_addr,
	input wire logic [csfw_pkg::WORD_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [csfw_pkg::WORD_W-1:0] o_rdata,
	input wire logic i_bit_wr,
	input wire logic [2:0] i_bit_sel,
	input wire logic i_bit_val,
	input wire logic i_alu_upd,
	input wire logic i_alu_carry,
	input wire logic i_alu_half,
	input wire logic i_alu_excess,
	input wire logic [csfw_pkg::WORD_W-1:0] i_acc,
	input wire logic [csfw_pkg::REG_IDX_W-1:0] i_reg_idx,
	output logic [csfw_pkg::DMEM_W-1:0] o_dmem_addr,
	output logic [csfw_pkg::BANK_W-1:0] o_bank_select_field,
	output logic [csfw_pkg::WORD_W-1:0] o_status_word
);
	import csfw_pkg::*;

	// ***********************************************
	// reset release
	// ***********************************************
	logic [1:0] rst_sync_reg; // two-stage release of the async reset
	logic rst_n;              // synchronised reset used everywhere below

	// assert at once, release after two edges
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ***********************************************
	// register decode
	// ***********************************************
	logic hit;          // address matches the status word
	logic byte_wr;      // whole-word software write
	logic [7:0] bit_mask; // one-hot mask for single-bit writes
	assign hit = (i_addr == STATUS_WORD_OFFSET);
	assign byte_wr = i_wr && hit;
	assign bit_mask = 8'h01 << i_bit_sel;

	// ***********************************************
	// stored fields
	// ***********************************************
	logic carry_flag_reg;        // carry or borrow from last arithmetic
	logic half_carry_flag_reg;   // nibble carry or borrow
	logic user_bit_zero_reg;     // software flag
	logic [1:0] bank_select_field_reg; // working register bank
	logic signed_excess_flag_reg; // signed overflow
	logic user_bit_one_reg;      // software flag
	logic parity_reg;            // registered accumulator parity

	// software-writable value of a bit: byte write, then bit write
	function automatic logic sw_val(input int pos, input logic cur);
		logic v;
		v = cur;
		if (byte_wr) begin
			v = i_wdata[pos];
		end
		if (i_bit_wr && bit_mask[pos]) begin
			v = i_bit_val;
		end
		return v;
	endfunction : sw_val

	// arithmetic flags: an alu update wins over a software write in the same cycle,
	// since the alu result is the more recent event
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			carry_flag_reg <= STATUS_WORD_RESET[CARRY_BIT];
			half_carry_flag_reg <= STATUS_WORD_RESET[HALF_BIT];
			signed_excess_flag_reg <= STATUS_WORD_RESET[EXCESS_BIT];
		end else if (i_alu_upd) begin
			carry_flag_reg <= i_alu_carry;
			half_carry_flag_reg <= i_alu_half;
			signed_excess_flag_reg <= i_alu_excess;
		end else begin
			carry_flag_reg <= sw_val(CARRY_BIT, carry_flag_reg);
			half_carry_flag_reg <= sw_val(HALF_BIT, half_carry_flag_reg);
			signed_excess_flag_reg <= sw_val(EXCESS_BIT, signed_excess_flag_reg);
		end
	end

	// software flags: alu activity never touches them
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			user_bit_zero_reg <= STATUS_WORD_RESET[USER0_BIT];
			user_bit_one_reg <= STATUS_WORD_RESET[USER1_BIT];
		end else begin
			user_bit_zero_reg <= sw_val(USER0_BIT, user_bit_zero_reg);
			user_bit_one_reg <= sw_val(USER1_BIT, user_bit_one_reg);
		end
	end

	// bank select, software controlled
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_select_field_reg <= STATUS_WORD_RESET[BANK_HI_BIT:BANK_LO_BIT];
		end else begin
			bank_select_field_reg <= {sw_val(BANK_HI_BIT, bank_select_field_reg[1]),
				sw_val(BANK_LO_BIT, bank_select_field_reg[0])};
		end
	end

	// parity tracks the accumulator every cycle; writes to bit zero are ignored
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			parity_reg <= 1'b0;
		end else begin
			parity_reg <= ^i_acc;
		end
	end

	// ***********************************************
	// assembled word and read port
	// ***********************************************
	logic [7:0] word; // current status word
	assign word = {carry_flag_reg, half_carry_flag_reg, user_bit_zero_reg,
		bank_select_field_reg, signed_excess_flag_reg, user_bit_one_reg, parity_reg};

	// read data one cycle after the strobe, zero otherwise and for other addresses
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd && hit) begin
			o_rdata <= word;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// registered copies for the core
	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_status_word <= STATUS_WORD_RESET;
			o_bank_select_field <= STATUS_WORD_RESET[BANK_HI_BIT:BANK_LO_BIT];
		end else begin
			o_status_word <= word;
			o_bank_select_field <= bank_select_field_reg;
		end
	end

	// ***********************************************
	// working register address
	// ***********************************************
	csfw_bank_addr u_bank_addr (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(rst_n),
		.i_bank(bank_select_field_reg),
		.i_reg_idx(i_reg_idx),
		.o_dmem_addr(o_dmem_addr)
	);

	// ***********************************************
	// assertions
	// ***********************************************
	// flags take the alu result one edge after the update strobe
	a_carry_follows_alu: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		i_alu_upd |=> carry_flag_reg == $past(i_alu_carry))
		else $error("carry flag did not follow alu");
	a_half_follows_alu: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		i_alu_upd |=> half_carry_flag_reg == $past(i_alu_half))
		else $error("half carry did not follow alu");
	// software flags move only on a write aimed at them, never on alu activity
	a_user_zero_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		!byte_wr && !(i_bit_wr && i_bit_sel == 3'h5) |=> $stable(user_bit_zero_reg))
		else $error("user bit zero changed without write");
	a_user_one_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		!byte_wr && !(i_bit_wr && i_bit_sel == 3'h1) |=> $stable(user_bit_one_reg))
		else $error("user bit one changed without write");
	// bank field reaches the core copy two edges after the word write
	a_bank_write: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		byte_wr && !i_bit_wr |=> ##1 o_bank_select_field == $past(i_wdata[4:3], 2))
		else $error("bank field not written");
	// excess flag behaves like the other arithmetic flags
	a_excess_follows: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		i_alu_upd |=> signed_excess_flag_reg == $past(i_alu_excess))
		else $error("excess flag did not follow alu");
	// parity passes two flops on its way to the core copy
	a_parity_track: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		1'b1 |=> ##1 o_status_word[0] == ^$past(i_acc, 2))
		else $error("parity not odd parity of accumulator");
	// a hit read returns the word as it stood at the strobe
	a_read_timing: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		i_rd && hit |=> o_rdata == $past(word))
		else $error("read data wrong");
	// read data fall back to zero unless a hit read was strobed
	a_read_idle_zero: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		!(i_rd && hit) |=> o_rdata == 8'h00)
		else $error("read data not zero when idle");
	// without an alu update software may load the arithmetic flags
	a_flag_sw_write: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		byte_wr && !i_bit_wr && !i_alu_upd |=> carry_flag_reg == $past(i_wdata[CARRY_BIT])
			&& signed_excess_flag_reg == $past(i_wdata[EXCESS_BIT]))
		else $error("arithmetic flags not loaded by software");
	// the core copy of the word trails the fields by one edge
	a_status_copy: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
		1'b1 |=> o_status_word == $past(word))
		else $error("status word copy wrong");
	c_alu_carry: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
		i_alu_upd && i_alu_carry);
	c_bit_write: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
		i_bit_wr && i_bit_sel == 3'd5);
	c_alu_and_write: cover property (@(posedge i_sys_clk) disable iff (!rst_n)
		i_alu_upd && byte_wr);
endmodule : csfw_status_word

// [tb/tb_top.sv]
// self-checking bench for the program status word block
`timescale 1ns/1ps
module tb_top;
	import csfw_pkg::*;
	// ***************
	// stimulus and observed signals
	// ***************
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0; // active low, held at start
	logic [7:0] addr = 8'h00, wdata = 8'h00, acc = 8'h00;
	logic wr = 1'b0, rd = 1'b0, bit_wr = 1'b0, bit_val = 1'b0;
	logic upd = 1'b0, cy = 1'b0, hc = 1'b0, ov = 1'b0;
	logic [2:0] bit_sel = 3'h0, idx = 3'h0;
	logic [7:0] rdata, dmem, word;
	logic [1:0] bank;
	logic [7:0] model = 8'h00; // expected stored bits, parity excluded
	int bad_count = 0, n_tests = 0, cycles = 0, i, j;
	csfw_status_word uut (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_bit_wr(bit_wr),
		.i_bit_sel(bit_sel), .i_bit_val(bit_val), .i_alu_upd(upd), .i_alu_carry(cy),
		.i_alu_half(hc), .i_alu_excess(ov), .i_acc(acc), .i_reg_idx(idx),
		.o_dmem_addr(dmem), .o_bank_select_field(bank), .o_status_word(word));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	// ***************
	// expectation helpers and bus tasks
	// ***************
	function automatic logic [7:0] exp_word();
		return {model[7:1], ^acc}; // parity is odd count of ones
	endfunction : exp_word
	function automatic logic [7:0] exp_addr(input logic [1:0] b, input logic [2:0] n);
		return 8'(b * 8 + n); // bank base plus register number
	endfunction : exp_addr
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
			bad_count++;
		end
	endtask : chk
	// one cycle of any mix of write and alu strobes, then let the outputs settle
	task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic bw, input logic [2:0] bs, input logic bv, input logic u,
		input logic [2:0] f, input logic [7:0] ac, input logic [2:0] n);
		@(posedge sys_clk);
		wr <= w;
		addr <= a;
		wdata <= d;
		bit_wr <= bw;
		bit_sel <= bs;
		bit_val <= bv;
		upd <= u;
		{cy, hc, ov} <= f;
		acc <= ac;
		idx <= n;
		if (w && a == STATUS_WORD_OFFSET) model = d;
		if (bw && bs != 3'h0) model[bs] = bv; // bit write beats byte write
		if (u) model = {f[2], f[1], model[5:3], f[0], model[1:0]}; // alu beats software
		@(posedge sys_clk);
		wr <= 1'b0;
		bit_wr <= 1'b0;
		upd <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : op
	task automatic check_all();
		chk(exp_word(), word);
		chk({6'h00, model[4:3]}, bank);
		chk(exp_addr(model[4:3], idx), dmem);
	endtask : check_all
	// read strobe, data in the next cycle only
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 chk(exp, rdata);
		@(posedge sys_clk);
		#1 chk(8'h00, rdata);
	endtask : rd_chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test
	// hang guard: a whole run needs about a thousand cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			bad_count++;
			end_of_test();
		end
	end
	// ***************
	// main sequence
	// ***************
	initial begin
		i = $urandom(32'hAC579964);
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk(STATUS_WORD_RESET, word); // reset value
		// random mix, sometimes an unmapped address
		for (i = 0; i < 200; i++) begin
			op(1'($urandom), ($urandom_range(0, 3) == 0) ? 8'($urandom) : STATUS_WORD_OFFSET,
				8'($urandom), 1'($urandom), 3'($urandom), 1'($urandom), 1'($urandom),
				3'($urandom), 8'($urandom), 3'($urandom));
			check_all();
		end
		// alu and byte write together, then byte and bit write together
		op(1'b1, STATUS_WORD_OFFSET, 8'hFF, 1'b0, 3'h0, 1'b0, 1'b1, 3'h0, 8'h01, 3'h7);
		check_all();
		op(1'b1, STATUS_WORD_OFFSET, 8'h00, 1'b1, 3'h5, 1'b1, 1'b0, 3'h0, 8'h03, 3'h0);
		check_all();
		// every bit, both values, bit zero must ignore the write and keep the accumulator parity
		for (j = 0; j < 16; j++) begin
			op(1'b0, 8'h00, 8'h00, 1'b1, 3'(j), j[3], 1'b0, 3'h0, 8'(j * 37), 3'(j));
			check_all();
		end
		rd_chk(STATUS_WORD_OFFSET, exp_word());
		rd_chk(8'hD1, 8'h00); // unmapped read
		// every bank with every register number
		for (j = 0; j < 32; j++) begin
			op(1'b1, STATUS_WORD_OFFSET, {3'h0, 2'(j >> 3), 3'h0}, 1'b0, 3'h0, 1'b0,
				1'b0, 3'h0, 8'h00, 3'(j));
			check_all();
		end
		// second reset in mid-run
		@(posedge sys_clk);
		reset_n <= 1'b0;
		@(posedge sys_clk);
		reset_n <= 1'b1;
		model = 8'h00;
		repeat (4) @(posedge sys_clk);
		#1 chk(STATUS_WORD_RESET, word); // reset value
		check_all();
		end_of_test();
	end
endmodule : tb_top
